// ### design/axil_write_join.sv
// axi4-lite write channel joiner: address and data in either order
`timescale 1ns/10ps
module axil_write_join
   import wake_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic wrOk,
   output logic wrStrobe,
   output logic [ADDR_W-1:0] wrAddr_q,
   output logic [DATA_W-1:0] wrData_q,
   output logic [3:0] wrStrb_q
);
   logic haveAw_q;
   logic haveW_q;
   logic haveAw_d;
   logic haveW_d;
   logic bvalid_d;
   logic awTake;
   logic wTake;

   assign awTake = awvalid & awready;
   assign wTake = wvalid & wready;
   // one write at a time: both halves held and no answer pending
   assign wrStrobe = haveAw_q & haveW_q & ~bvalid;
   assign haveAw_d = wrStrobe ? 1'b0 : (haveAw_q | awTake);
   assign haveW_d = wrStrobe ? 1'b0 : (haveW_q | wTake);
   assign bvalid_d = wrStrobe | (bvalid & ~bready);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         haveAw_q <= 1'b0;
         haveW_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         haveAw_q <= haveAw_d;
         haveW_q <= haveW_d;
         awready <= ~haveAw_d & ~bvalid_d;
         wready <= ~haveW_d & ~bvalid_d;
         bvalid <= bvalid_d;
         if (wrStrobe) begin
            bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrAddr_q <= '0;
         wrData_q <= '0;
         wrStrb_q <= '0;
      end else begin
         if (awTake) begin
            wrAddr_q <= awaddr;
         end
         if (wTake) begin
            wrData_q <= wdata;
            wrStrb_q <= wstrb;
         end
      end
   end
endmodule : axil_write_join

// ### design/sticky_flag.sv
// vector of sticky flags: hardware set beats software clear
`timescale 1ns/10ps
module sticky_flag #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flag_q
);
   logic [W-1:0] flag_d;

   // an event in the clearing cycle is kept
   assign flag_d = set | (flag_q & ~clr);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule : sticky_flag

// ### design/wake_event_status_logic.sv
// wake control/status and wake source registers behind axi4-lite
//
// Notes on behaviour
// (RQ1) pattern frame sets flag; write one clears
// (RQ2) broadcast frame sets flag; write one clears
// (RQ3) resume may auto-clear received-event flags
// (RQ4) resume may auto-clear every wake enable
// (RQ5) station address match wakes when enabled
// (RQ6) filter frame match wakes when enabled
// (RQ7) pattern frame wakes when enabled
// (RQ8) broadcast frame wakes when enabled
// (RQ9) no recording while entering suspend
// (RQ10) no recording once waking has begun
// (RQ11) all matching source bits set together
// (RQ12) source bits stay until software clears
// (RQ13) one source bit per pin event
// (RQ14) v6 and v4 syn source bits
// (RQ15) tx idle exit bit, gated, held low
// (RQ16) rx idle exit bit, gated, held low
// (RQ17) filter engine frame source bit
// (RQ18) station match frame source bit
// (RQ19) pattern and broadcast source bits
// (RQ20) filter frame source bit
// (RQ21) filter index loaded with filter source
// (RQ22) reserved source bits read zero
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module wake_event_status_logic
   import wake_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input wire logic clock,
   input wire logic rstn,
   // axi4-lite slave
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // receive filter, idle and pin events, one-cycle pulses; energyEfficientEnable is a level
   input wire logic broadcastFrameOk,
   input wire logic patternFrameOk,
   input wire logic stationFrameOk,
   input wire logic filterFrameOk,
   input wire logic [INDEX_W-1:0] filterIndex,
   input wire logic engineFrameOk,
   input wire logic v4SynOk,
   input wire logic v6SynOk,
   input wire logic lowpowerTxExit,
   input wire logic lowpowerRxExit,
   input wire logic [PINS-1:0] pinWakeEvent,
   input wire logic energyEfficientEnable,
   // suspend sequencing pulses
   input wire logic suspendStart,
   input wire logic suspendReached,
   input wire logic resumeDone,
   // wake request to the suspend controller, and the wake enables
   output logic wakeSignal_q,
   output logic [CTRL_EN_W-1:0] wakeEnables_q
);
   wake_state_t state_q;
   wake_state_t state_d;

   // write side
   logic wrStrobe;
   logic [ADDR_W-1:0] wrAddr_q;
   logic [DATA_W-1:0] wrData_q;
   logic [3:0] wrStrb_q;
   logic [DATA_W-1:0] laneMask;
   logic [DATA_W-1:0] wrBits;
   logic wrCtrl;
   logic wrSource;
   logic wrOptions;
   logic wrOk;

   // read side
   logic arTake;
   logic rvalid_d;
   logic rdHitCtrl;
   logic rdHitSource;
   logic rdHitOptions;
   logic rdHitState;
   logic rdOk;
   logic [DATA_W-1:0] rdValue;
   logic [DATA_W-1:0] ctrlView;
   logic [DATA_W-1:0] sourceView;
   logic [DATA_W-1:0] optionsView;
   logic [DATA_W-1:0] stateView;

   // control bits
   logic [CTRL_EN_W-1:0] enable_d;
   logic [OPT_W-1:0] options_q;
   logic [OPT_W-1:0] options_d;
   logic resumeClrFlags;
   logic resumeClrEn;
   logic [1:0] seenSet;
   logic [1:0] seenClr;
   logic [1:0] seen_q;

   // wake sources
   logic hitBcast;
   logic hitPattern;
   logic hitFilter;
   logic hitStation;
   logic hitRx;
   logic hitTx;
   logic [DATA_W-1:0] srcHit;
   logic anyHit;
   logic recording;
   logic wakeFire;
   logic [DATA_W-1:0] srcSet;
   logic [DATA_W-1:0] srcClr;
   logic [DATA_W-1:0] srcFlags_q;
   logic [DATA_W-1:0] srcMask;
   logic [INDEX_W-1:0] index_q;
   logic [INDEX_W-1:0] index_d;

   axil_write_join u_write (
      .clock(clock),
      .rstn(rstn),
      .awvalid(awvalid),
      .awready(awready),
      .awaddr(awaddr),
      .wvalid(wvalid),
      .wready(wready),
      .wdata(wdata),
      .wstrb(wstrb),
      .bvalid(bvalid),
      .bready(bready),
      .bresp(bresp),
      .wrOk(wrOk),
      .wrStrobe(wrStrobe),
      .wrAddr_q(wrAddr_q),
      .wrData_q(wrData_q),
      .wrStrb_q(wrStrb_q)
   );

   // write decode; byte lanes gate every bit written
   assign laneMask = {{8{wrStrb_q[3]}}, {8{wrStrb_q[2]}}, {8{wrStrb_q[1]}}, {8{wrStrb_q[0]}}};
   assign wrBits = wrData_q & laneMask;
   assign wrCtrl = wrStrobe & (wrAddr_q == CTRL_OFF);
   assign wrSource = wrStrobe & (wrAddr_q == SOURCE_OFF);
   assign wrOptions = wrStrobe & (wrAddr_q == OPTIONS_OFF);
   assign wrOk = (wrAddr_q == CTRL_OFF) | (wrAddr_q == SOURCE_OFF)
      | (wrAddr_q == OPTIONS_OFF) | (wrAddr_q == STATE_OFF);

   assign resumeClrFlags = options_q[OPT_RESUME_CLR_FLAGS];
   assign resumeClrEn = options_q[OPT_RESUME_CLR_EN];

   // enables: a software write in the resume cycle takes effect
   always_comb begin
      enable_d = wakeEnables_q;
      // (RQ4) resume clears enables
      if (resumeDone & resumeClrEn) begin
         enable_d = '0;
      end
      if (wrCtrl & wrStrb_q[0]) begin
         enable_d = wrData_q[CTRL_EN_W-1:0];
      end
   end

   always_comb begin
      options_d = options_q;
      // (RQ4) idle exit enables too
      if (resumeDone & resumeClrEn) begin
         options_d[OPT_RX_EXIT_EN] = 1'b0;
         options_d[OPT_TX_EXIT_EN] = 1'b0;
      end
      if (wrOptions & wrStrb_q[0]) begin
         options_d = wrData_q[OPT_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wakeEnables_q <= '0;
         options_q <= '0;
      end else begin
         wakeEnables_q <= enable_d;
         options_q <= options_d;
      end
   end

   // (RQ1) pattern frame flag
   assign seenSet[1] = patternFrameOk;
   // (RQ2) broadcast frame flag
   assign seenSet[0] = broadcastFrameOk;
   // (RQ3) resume clears flags
   assign seenClr[1] = (wrCtrl & wrBits[CTRL_PATTERN_SEEN]) | (resumeDone & resumeClrFlags);
   assign seenClr[0] = (wrCtrl & wrBits[CTRL_BCAST_SEEN]) | (resumeDone & resumeClrFlags);

   sticky_flag #(
      .W(2)
   ) u_seen (
      .clock(clock),
      .rstn(rstn),
      .set(seenSet),
      .clr(seenClr),
      .flag_q(seen_q)
   );

   // (RQ8) broadcast wake gate
   assign hitBcast = broadcastFrameOk & wakeEnables_q[CTRL_BROADCAST_WAKE_EN];
   // (RQ7) pattern wake gate
   assign hitPattern = patternFrameOk & wakeEnables_q[CTRL_PATTERN_EN];
   // (RQ6) filter frame wake gate
   assign hitFilter = filterFrameOk & wakeEnables_q[CTRL_FILTER_EN];
   // (RQ5) station match wake gate
   assign hitStation = stationFrameOk & wakeEnables_q[CTRL_STATION_EN];
   // (RQ16) rx idle exit gate
   assign hitRx = lowpowerRxExit & options_q[OPT_RX_EXIT_EN] & energyEfficientEnable;
   // (RQ15) tx idle exit gate
   assign hitTx = lowpowerTxExit & options_q[OPT_TX_EXIT_EN] & energyEfficientEnable;

   always_comb begin
      srcHit = '0;
      // (RQ20) filter frame bit
      srcHit[SRC_FILTER] = hitFilter;
      // (RQ19) broadcast and pattern bits
      srcHit[SRC_BCAST] = hitBcast;
      srcHit[SRC_PATTERN] = hitPattern;
      // (RQ18) station match bit
      srcHit[SRC_STATION] = hitStation;
      // (RQ17) filter engine bit
      srcHit[SRC_ENGINE] = engineFrameOk;
      srcHit[SRC_RX_EXIT] = hitRx;
      srcHit[SRC_TX_EXIT] = hitTx;
      // (RQ14) syn frame bits
      srcHit[SRC_V4_SYN] = v4SynOk;
      srcHit[SRC_V6_SYN] = v6SynOk;
      // (RQ13) one bit per pin
      srcHit[SRC_PIN_LSB +: PINS] = pinWakeEvent;
   end

   // (RQ22) only flag bits are ever stored
   always_comb begin
      srcMask = '0;
      srcMask[SRC_V6_SYN:SRC_FILTER] = '1;
      srcMask[SRC_PIN_LSB +: PINS] = '1;
   end

   assign anyHit = |srcHit;
   // (RQ9) armed only once suspend is reached
   // (RQ10) ignored after waking begins
   assign recording = (state_q == ARMED);
   assign wakeFire = recording & anyHit;
   // (RQ11) every matching bit in one go
   assign srcSet = wakeFire ? (srcHit & srcMask) : '0;
   // (RQ12) only software writes clear, idle exit bits aside
   // (RQ15) held low while idle saving is off
   // (RQ16) rx bit held low
   always_comb begin
      srcClr = wrSource ? (wrBits & srcMask) : '0;
      if (!energyEfficientEnable) begin
         srcClr[SRC_RX_EXIT] = 1'b1;
         srcClr[SRC_TX_EXIT] = 1'b1;
      end
   end

   sticky_flag #(
      .W(DATA_W)
   ) u_source (
      .clock(clock),
      .rstn(rstn),
      .set(srcSet),
      .clr(srcClr),
      .flag_q(srcFlags_q)
   );

   // (RQ21) filter index loads with its bit
   always_comb begin
      index_d = index_q;
      if (wrSource) begin
         index_d = index_q & ~wrBits[SRC_INDEX_LSB +: INDEX_W];
      end
      if (wakeFire & hitFilter) begin
         index_d = filterIndex;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         index_q <= '0;
      end else begin
         index_q <= index_d;
      end
   end

   // suspend sequencing; a resume always returns to awake
   always_comb begin
      state_d = state_q;
      case (state_q)
         AWAKE: begin
            if (suspendStart) begin
               state_d = ENTERING;
            end
         end
         ENTERING: begin
            if (suspendReached) begin
               state_d = ARMED;
            end
         end
         ARMED: begin
            if (wakeFire) begin
               state_d = WAKING;
            end
         end
         WAKING: begin
            state_d = WAKING;
         end
         default: begin
            state_d = AWAKE;
         end
      endcase
      if (resumeDone) begin
         state_d = AWAKE;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= AWAKE;
         wakeSignal_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wakeSignal_q <= (state_d == WAKING);
      end
   end

   // read views
   always_comb begin
      ctrlView = '0;
      ctrlView[CTRL_EN_W-1:0] = wakeEnables_q;
      ctrlView[CTRL_BCAST_SEEN] = seen_q[0];
      ctrlView[CTRL_PATTERN_SEEN] = seen_q[1];
      sourceView = srcFlags_q & srcMask;
      sourceView[SRC_INDEX_LSB +: INDEX_W] = index_q;
      optionsView = '0;
      optionsView[OPT_W-1:0] = options_q;
      stateView = '0;
      stateView[STATE_CODE_LSB +: 2] = state_q;
      stateView[STATE_SIGNAL] = wakeSignal_q;
   end

   assign rdHitCtrl = (araddr == CTRL_OFF);
   assign rdHitSource = (araddr == SOURCE_OFF);
   assign rdHitOptions = (araddr == OPTIONS_OFF);
   assign rdHitState = (araddr == STATE_OFF);
   assign rdOk = rdHitCtrl | rdHitSource | rdHitOptions | rdHitState;
   assign rdValue = ({DATA_W{rdHitCtrl}} & ctrlView)
      | ({DATA_W{rdHitSource}} & sourceView)
      | ({DATA_W{rdHitOptions}} & optionsView)
      | ({DATA_W{rdHitState}} & stateView);

   // one read in flight; address taken only while no answer waits
   assign arTake = arvalid & arready;
   assign rvalid_d = arTake | (rvalid & ~rready);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         arready <= ~rvalid_d;
         rvalid <= rvalid_d;
         if (arTake) begin
            rdata <= rdValue;
            rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end
endmodule : wake_event_status_logic

// ### design/wake_pkg.sv
// shared offsets, field positions and states of the wake event logic
package wake_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PIN_COUNT = 8;
   localparam int INDEX_W = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h140;
   localparam logic [ADDR_W-1:0] SOURCE_OFF = 12'h144;
   localparam logic [ADDR_W-1:0] OPTIONS_OFF = 12'h148;
   localparam logic [ADDR_W-1:0] STATE_OFF = 12'h14c;

   // wake_control_status fields
   localparam int CTRL_BROADCAST_WAKE_EN = 0;
   localparam int CTRL_PATTERN_EN = 1;
   localparam int CTRL_FILTER_EN = 2;
   localparam int CTRL_STATION_EN = 3;
   localparam int CTRL_BCAST_SEEN = 4;
   localparam int CTRL_PATTERN_SEEN = 5;
   localparam int CTRL_EN_W = 4;

   // wake_options fields
   localparam int OPT_RESUME_CLR_FLAGS = 0;
   localparam int OPT_RESUME_CLR_EN = 1;
   localparam int OPT_RX_EXIT_EN = 2;
   localparam int OPT_TX_EXIT_EN = 3;
   localparam int OPT_W = 4;

   // wake_source fields
   localparam int SRC_INDEX_LSB = 0;
   localparam int SRC_FILTER = 8;
   localparam int SRC_BCAST = 9;
   localparam int SRC_PATTERN = 10;
   localparam int SRC_STATION = 11;
   localparam int SRC_ENGINE = 12;
   localparam int SRC_RX_EXIT = 13;
   localparam int SRC_TX_EXIT = 14;
   localparam int SRC_V4_SYN = 15;
   localparam int SRC_V6_SYN = 16;
   localparam int SRC_PIN_LSB = 20;

   // wake_state fields
   localparam int STATE_CODE_LSB = 0;
   localparam int STATE_SIGNAL = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      AWAKE,
      ENTERING,
      ARMED,
      WAKING
   } wake_state_t;
endpackage : wake_pkg

// ### verif/host_model.sv
// axi4-lite host standing for software on the register path
`timescale 1ns/10ps
module host_model
   import wake_pkg::*;
(
   input wire logic clock,
   output logic awvalid,
   input wire logic awready,
   output logic [ADDR_W-1:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [DATA_W-1:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   output logic arvalid,
   input wire logic arready,
   output logic [ADDR_W-1:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [1:0] rresp
);
   int hung = 0;
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = '0;
      wdata = '0;
      wstrb = 4'h0;
      araddr = '0;
   end
   // handshakes are judged at the rising edge, on the levels that stood before it
   task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
      logic awT, wT, bT;
      int n;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bT = 1'b0;
      n = 0;
      while (!bT && n < 100) begin
         @(posedge clock);
         awT = awvalid && awready;
         wT = wvalid && wready;
         bT = bvalid && bready;
         if (bT) r = bresp;
         n++;
         if (awT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!bT) hung++;
      @(posedge clock);
   endtask : write
   task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
      logic arT, rT;
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rT = 1'b0;
      n = 0;
      while (!rT && n < 100) begin
         @(posedge clock);
         arT = arvalid && arready;
         rT = rvalid && rready;
         if (rT) begin
            d = rdata;
            r = rresp;
         end
         n++;
         if (arT) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!rT) hung++;
      @(posedge clock);
   endtask : read
endmodule : host_model

// ### verif/tb_top.sv
// register and wake sequencing bench for the wake event block
`timescale 1ns/10ps
module tb_top;
   import wake_pkg::*;
   logic clock, rstn, eee, wakeSignal;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb, wakeEnables;
   logic [1:0] bresp, rresp;
   logic [19:0] ev;
   logic [4:0] idx;
   int errors, samplesChecked;
   wake_event_status_logic i_wake_event_status_logic (.clock(clock), .rstn(rstn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .broadcastFrameOk(ev[0]),
      .patternFrameOk(ev[1]), .stationFrameOk(ev[2]), .filterFrameOk(ev[3]), .filterIndex(idx),
      .engineFrameOk(ev[4]), .v4SynOk(ev[5]), .v6SynOk(ev[6]), .lowpowerTxExit(ev[7]), .lowpowerRxExit(ev[8]),
      .pinWakeEvent(ev[19:12]), .energyEfficientEnable(eee), .suspendStart(ev[9]), .suspendReached(ev[10]),
      .resumeDone(ev[11]), .wakeSignal_q(wakeSignal), .wakeEnables_q(wakeEnables));
   host_model i_host_model (.clock(clock), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic wrap_up();
      if (errors == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         errors++;
      end
      // a hung handshake ends the run at once
      if (i_host_model.hung != 0) begin
         errors++;
         wrap_up();
      end
   endtask : check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      i_host_model.write(a, d, r);
      check("bresp", {30'h0, er}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] er, input logic [31:0] ed);
      logic [31:0] d;
      logic [1:0] r;
      i_host_model.read(a, d, r);
      check("rresp", {30'h0, er}, {30'h0, r});
      check($sformatf("rdata at %h", a), ed, d);
   endtask : rd
   // one-cycle pulse on the event inputs, then one cycle for the registers
   task automatic fire(input logic [19:0] v);
      ev <= v;
      @(posedge clock);
      ev <= 20'h0;
      @(posedge clock);
   endtask : fire
   initial begin
      rstn = 1'b0;
      eee = 1'b1;
      ev = 20'h0;
      idx = 5'h13;
      errors = 0;
      samplesChecked = 0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      rd(CTRL_OFF, RESP_OKAY, 32'h0);
      rd(SOURCE_OFF, RESP_OKAY, 32'h0);
      rd(12'h000, RESP_SLVERR, 32'h0);
      wr(12'h000, 32'hffffffff, RESP_SLVERR);
      wr(CTRL_OFF, 32'h0000000f, RESP_OKAY);
      wr(OPTIONS_OFF, 32'h0000000f, RESP_OKAY);
      check("enables", 32'hf, {28'h0, wakeEnables});
      fire(20'h00003);
      rd(CTRL_OFF, RESP_OKAY, 32'h3f);
      rd(SOURCE_OFF, RESP_OKAY, 32'h0);
      wr(CTRL_OFF, 32'h0000003f, RESP_OKAY);
      rd(CTRL_OFF, RESP_OKAY, 32'h0f);
      fire(20'h00200);
      fire(20'h00001);
      rd(SOURCE_OFF, RESP_OKAY, 32'h0);
      fire(20'h00400);
      rd(STATE_OFF, RESP_OKAY, 32'h2);
      fire(20'h5a1ff);
      check("wake", 32'h1, {31'h0, wakeSignal});
      idx <= 5'h0c;
      fire(20'ha5009);
      rd(STATE_OFF, RESP_OKAY, 32'h13);
      rd(SOURCE_OFF, RESP_OKAY, 32'h05a1ff13);
      fire(20'h00800);
      check("wake", 32'h0, {31'h0, wakeSignal});
      rd(CTRL_OFF, RESP_OKAY, 32'h0);
      rd(OPTIONS_OFF, RESP_OKAY, 32'h3);
      rd(SOURCE_OFF, RESP_OKAY, 32'h05a1ff13);
      eee <= 1'b0;
      @(posedge clock);
      rd(SOURCE_OFF, RESP_OKAY, 32'h05a19f13);
      wr(SOURCE_OFF, 32'hffffffff, RESP_OKAY);
      rd(SOURCE_OFF, RESP_OKAY, 32'h0);
      wr(CTRL_OFF, 32'h00000001, RESP_OKAY);
      wr(OPTIONS_OFF, 32'h0, RESP_OKAY);
      fire(20'h00200);
      fire(20'h00400);
      fire(20'h0018e);
      check("wake", 32'h0, {31'h0, wakeSignal});
      rd(SOURCE_OFF, RESP_OKAY, 32'h0);
      fire(20'h00001);
      rd(SOURCE_OFF, RESP_OKAY, 32'h00000200);
      fire(20'h00800);
      rd(CTRL_OFF, RESP_OKAY, 32'h31);
      wrap_up();
   end
endmodule : tb_top

// ### verif/wake_event_assertions.sv
// port-level checks of wake sequencing and enable handling
`timescale 1ns/10ps
module wake_event_assertions
   import wake_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic bvalid,
   input wire logic broadcastFrameOk,
   input wire logic patternFrameOk,
   input wire logic stationFrameOk,
   input wire logic filterFrameOk,
   input wire logic engineFrameOk,
   input wire logic v4SynOk,
   input wire logic v6SynOk,
   input wire logic lowpowerTxExit,
   input wire logic lowpowerRxExit,
   input wire logic [PINS-1:0] pinWakeEvent,
   input wire logic energyEfficientEnable,
   input wire logic suspendStart,
   input wire logic suspendReached,
   input wire logic resumeDone,
   input wire logic wakeSignal_q,
   input wire logic [CTRL_EN_W-1:0] wakeEnables_q
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   logic enteringQ;
   logic armedQ;
   // idle exits count only while energy-efficient operation is on
   wire exitHit = (lowpowerTxExit || lowpowerRxExit) && energyEfficientEnable;
   wire frameHit = (broadcastFrameOk && wakeEnables_q[CTRL_BROADCAST_WAKE_EN]) || (patternFrameOk && wakeEnables_q[CTRL_PATTERN_EN])
      || (filterFrameOk && wakeEnables_q[CTRL_FILTER_EN]) || (stationFrameOk && wakeEnables_q[CTRL_STATION_EN]);
   wire hitAny = frameHit || exitHit || engineFrameOk || v4SynOk || v6SynOk || (|pinWakeEvent);
   // phase mirror; a suspend start in any phase sets enteringQ
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         enteringQ <= 1'b0;
         armedQ <= 1'b0;
      end else begin
         enteringQ <= suspendStart || (enteringQ && !suspendReached && !resumeDone);
         armedQ <= !resumeDone && !wakeSignal_q && ((enteringQ && suspendReached) || armedQ);
      end
   end
   property armedWake(logic hit, logic en);
      armedQ && !wakeSignal_q && !resumeDone && hit && en |=> wakeSignal_q;
   endproperty
   chk_station_wakes: assert property (armedWake(stationFrameOk, wakeEnables_q[CTRL_STATION_EN]))
      else $error("station frame did not raise wake");
   chk_filter_wakes: assert property (armedWake(filterFrameOk, wakeEnables_q[CTRL_FILTER_EN]))
      else $error("filter frame did not raise wake");
   chk_pattern_wakes: assert property (armedWake(patternFrameOk, wakeEnables_q[CTRL_PATTERN_EN]))
      else $error("pattern frame did not raise wake");
   chk_bcast_wakes: assert property (armedWake(broadcastFrameOk, wakeEnables_q[CTRL_BROADCAST_WAKE_EN]))
      else $error("broadcast frame did not raise wake");
   chk_entering_ignored: assert property (enteringQ && !wakeSignal_q |=> !wakeSignal_q)
      else $error("wake raised while entering suspend");
   chk_waking_holds: assert property (wakeSignal_q && !resumeDone |=> wakeSignal_q)
      else $error("wake dropped before resume");
   chk_wake_cause: assert property ($rose(wakeSignal_q) |-> $past(hitAny) && $past(armedQ))
      else $error("wake raised without an enabled cause");
   chk_enables_steady: assert property (!$stable(wakeEnables_q) |-> $rose(bvalid) || $past(resumeDone))
      else $error("enables changed without write or resume");
   cover property ($rose(wakeSignal_q));
   cover property (wakeSignal_q && resumeDone);
   cover property (armedQ && !wakeSignal_q && !hitAny && lowpowerTxExit);
endmodule : wake_event_assertions

bind wake_event_status_logic wake_event_assertions #(.PINS(PINS)) i_wake_event_assertions (
   .clock(clock), .rstn(rstn), .bvalid(bvalid), .broadcastFrameOk(broadcastFrameOk),
   .patternFrameOk(patternFrameOk), .stationFrameOk(stationFrameOk), .filterFrameOk(filterFrameOk),
   .engineFrameOk(engineFrameOk), .v4SynOk(v4SynOk), .v6SynOk(v6SynOk), .lowpowerTxExit(lowpowerTxExit),
   .lowpowerRxExit(lowpowerRxExit), .pinWakeEvent(pinWakeEvent), .energyEfficientEnable(energyEfficientEnable),
   .suspendStart(suspendStart), .suspendReached(suspendReached), .resumeDone(resumeDone),
   .wakeSignal_q(wakeSignal_q), .wakeEnables_q(wakeEnables_q)
);
